// [inc/sfl_pkg.sv]
// constants, codes and helpers of the serial link framer
package sfl_pkg;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CRC_BIT = 1;
  localparam int CTRL_RATE_BIT = 2;
  localparam int CTRL_HOSTVAR_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status fields
  localparam int ST_GO_BIT = 0;
  localparam int ST_STOP_BIT = 1;
  localparam int ST_CRCERR_BIT = 2;
  localparam int ST_LOST_BIT = 3;
  // framing figures
  localparam logic [9:0] MAX_DATA_WORDS = 10'h200;
  localparam logic [12:0] IDLE_SPAN_WORDS = 13'h1000;
  localparam logic [15:0] STOP_THR_LOW = 16'h0A61;
  localparam logic [15:0] STOP_THR_HIGH = 16'h186A;
  // ordered set layout: marker byte, code, zero fill
  localparam logic [7:0] OS_MARK = 8'hBC;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  typedef enum logic [4:0] {
    OS_SOF0 = 5'b00000,
    OS_STS0 = 5'b01000,
    OS_EOF_SYNC = 5'b01100,
    OS_EOF_DATA = 5'b01101,
    OS_ANNC = 5'b01110,
    OS_STOP = 5'b01111,
    OS_GO = 5'b10000,
    OS_IDLE = 5'b10001,
    OS_IDLE_POS = 5'b10010
  } sfl_os_t;

  typedef enum logic [2:0] {
    TX_GAP_FLOW = 3'b000,
    TX_GAP_IDLE = 3'b001,
    TX_SOF = 3'b010,
    TX_DATA = 3'b011,
    TX_STS = 3'b100,
    TX_EOF = 3'b101
  } sfl_tx_state_t;

  function automatic logic [31:0] sfl_os_word(input logic [4:0] code);
    sfl_os_word = {OS_MARK, 3'h0, code, 16'h0000};
  endfunction

  // start code: pio1,pio2,dir selects one of eight
  function automatic logic [4:0] sfl_sof_code(input logic [2:0] bits);
    sfl_sof_code = {2'b00, bits};
  endfunction

  // status code: overflow,not-ready selects one of four
  function automatic logic [4:0] sfl_sts_code(input logic [1:0] bits);
    sfl_sts_code = {3'b010, bits};
  endfunction
endpackage

// [tb/sfl_framer_checker.sv]
// port assertions for the serial link framer
`timescale 1ns/1ps
module sfl_framer_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // fifo head and link
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_sync,
  input wire logic tx_sync_dv,
  input wire logic tx_ready,
  input wire logic [31:0] lnk_tx_word,
  input wire logic lnk_tx_k
);
  import sfl_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [4:0] code;
  logic [10:0] pops_reg;
  logic bad;
  logic ann_reg;
  assign code = lnk_tx_word[20:16];
  assign bad = paddr != OFF_CTRL && paddr != OFF_STATUS;
  // data pops since the last start word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pops_reg <= 11'h000;
    else if (lnk_tx_k && code < 5'h08)
      pops_reg <= 11'h000;
    else if (tx_ready && !tx_sync)
      pops_reg <= pops_reg + 11'h001;
  // an announce makes the next sync pop a data word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ann_reg <= 1'b0;
    else if (lnk_tx_k && code == 5'h0E)
      ann_reg <= 1'b1;
    else if (lnk_tx_k && (code == 5'h0C || code == 5'h0D))
      ann_reg <= 1'b0;
  property p_form; lnk_tx_k |-> lnk_tx_word[31:21] == {OS_MARK, 3'h0} && lnk_tx_word[15:0] == 16'h0000; endproperty
  property p_word; tx_ready && (!tx_sync || (tx_sync_dv && ann_reg)) |=> !lnk_tx_k && lnk_tx_word == $past(tx_data);
  endproperty
  property p_sync; tx_ready && tx_sync && !(tx_sync_dv && ann_reg) |=> lnk_tx_k && code < 5'h08; endproperty
  property p_pop_valid; tx_ready |-> tx_valid; endproperty
  property p_space; tx_ready |=> !tx_ready [*4]; endproperty
  property p_len; pops_reg <= {1'b0, MAX_DATA_WORDS}; endproperty
  property p_close; $changed(lnk_tx_word) && lnk_tx_k && code inside {[5'h08:5'h0B]}
    |-> ##[1:16] lnk_tx_k && code inside {5'h0C, 5'h0D}; endproperty
  property p_gap; $changed(lnk_tx_word) && lnk_tx_k && code inside {5'h0C, 5'h0D}
    |-> ##[1:40] lnk_tx_k && code == OS_IDLE; endproperty
  property p_err; psel && penable |-> pslverr == bad; endproperty
  property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
  a_form: assert property (p_form) else $error("ordered set layout");
  a_word: assert property (p_word) else $error("popped word not sent");
  a_sync: assert property (p_sync) else $error("sync marker not at start");
  a_pop_valid: assert property (p_pop_valid) else $error("pop of empty head");
  a_space: assert property (p_space) else $error("pops too close");
  a_len: assert property (p_len) else $error("frame too long");
  a_close: assert property (p_close) else $error("no end after status");
  a_gap: assert property (p_gap) else $error("no idle in gap");
  a_err: assert property (p_err) else $error("error flag wrong");
  a_err_idle: assert property (p_err_idle) else $error("error flag outside access");
  c_sof: cover property (lnk_tx_k && code < 5'h08);
  c_sync_end: cover property (lnk_tx_k && code == 5'h0C);
  c_err: cover property (pslverr);
  c_marker: cover property (tx_ready && tx_sync);
endmodule

bind sfl_framer sfl_framer_checker sfl_framer_checker_i (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .tx_valid, .tx_data, .tx_sync, .tx_sync_dv, .tx_ready, .lnk_tx_word, .lnk_tx_k);

// [tb/sfl_framer_tb.sv]
// framer bench: apb access, fifo feed, link word checks
`timescale 1ns/1ps
module sfl_framer_tb;
  import sfl_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, saw_ann, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rx_data, lnk_rx_word, lnk_tx_word, rd;
  logic tx_valid = 1'b0, tx_sync = 1'b0, tx_sync_dv = 1'b0;
  logic [31:0] tx_data = 32'h0;
  logic tx_ovf, tx_ready, pio1, pio2, dir_n, nrdy_n, lclk, lnk_rx_k, lnk_tx_k;
  logic rx_valid, rx_sync, rx_sync_dv, rx_pio1, rx_pio2, rx_dir_n, rx_nrdy_n, rx_remote_ovf;
  logic [15:0] rx_free;
  logic [4:0] c;
  logic [33:0] txq[$];
  logic [31:0] rxq[$];
  int fail_count, n_tests, nsync;
  sfl_framer sfl_framer_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_valid, .tx_data, .tx_sync, .tx_sync_dv, .tx_ovf, .tx_ready, .pio1, .pio2, .dir_n, .nrdy_n,
    .rx_free, .rx_valid, .rx_data, .rx_sync, .rx_sync_dv, .rx_pio1, .rx_pio2, .rx_dir_n, .rx_nrdy_n,
    .rx_remote_ovf, .lclk, .lnk_rx_word, .lnk_rx_k, .lnk_tx_word, .lnk_tx_k);
  sfl_remote_node sfl_remote_node_i (.lclk, .lnk_rx_word, .lnk_rx_k, .go);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  function automatic logic [31:0] crc1(input logic [31:0] w);
    logic [31:0] r;
    r = CRC_INIT;
    for (int i = 31; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ (r[31] ^ w[i] ? CRC_POLY : 32'h0000_0000);
    return r;
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // next link word with code in lo..hi
  task wait_k(input int lo, input int hi);
    for (int i = 0; i < 400; i++)
    begin
      @(posedge lclk);
      c = lnk_tx_word[20:16];
      if (lnk_tx_k === 1'b1 && c == 5'h0E)
        saw_ann = 1'b1;
      if (lnk_tx_k === 1'b1 && c >= lo && c <= hi)
        return;
    end
    fail_count++;
    test_done;
  endtask
  task data_is(input logic [31:0] e);
    int i;
    i = 0;
    do
    begin
      @(posedge lclk);
      i++;
    end
    while (lnk_tx_k !== 1'b0 && i < 400);
    chk("data word", e, lnk_tx_word);
    if (lnk_tx_k !== 1'b0)
    begin
      fail_count++;
      test_done;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    if (tx_ready === 1'b1 && txq.size() != 0)
      void'(txq.pop_front());
    tx_valid <= txq.size() != 0;
    {tx_sync, tx_sync_dv, tx_data} <= txq.size() != 0 ? txq[0] : 34'h0;
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (rx_sync === 1'b1)
      nsync++;
  end
  initial
  begin
    {psel, penable, pwrite, tx_ovf, pio1, pio2, go, saw_ann, presetn} = 9'h000;
    {dir_n, nrdy_n, ce} = 3'b111;
    {paddr, pwdata, rx_free} = {8'h00, 32'h0, 16'hFFFF};
    {fail_count, n_tests, nsync} = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 0);
    chk("ctrl reset", CTRL_RESET, rd);
    apb(0, OFF_STATUS, 0);
    chk("status reset", 0, rd);
    apb(1, 8'h08, 32'hF);
    chk("unmapped error", 1, er);
    apb(0, 8'h08, 0);
    chk("unmapped read", 0, rd);
    apb(1, OFF_CTRL, 32'h1);
    apb(0, OFF_CTRL, 0);
    chk("ctrl", 1, rd);
    $display("test registers done");
    txq.push_back({2'b00, 32'hC0DE0001});
    txq.push_back({2'b00, 32'hC0DE0002});
    repeat (40) @(posedge lclk);
    chk("held in stop", 2, txq.size());
    go = 1'b1;
    data_is(32'hC0DE0001);
    data_is(32'hC0DE0002);
    wait_k(12, 13);
    chk("data end", 13, c);
    apb(0, OFF_STATUS, 0);
    chk("remote go", 1, rd);
    $display("test flow done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      {pio1, pio2, dir_n} <= {i[2], i[1], !i[0]};
      repeat (3) wait_k(0, 7);
      chk("start code", i, c);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      {tx_ovf, nrdy_n} <= {i[1], !i[0]};
      repeat (3) wait_k(8, 11);
      chk("status code", 8 + i, c);
    end
    $display("test side codes done");
    txq.push_back({2'b00, 32'hC0DE0003});
    txq.push_back({2'b10, 32'h0});
    data_is(32'hC0DE0003);
    wait_k(12, 13);
    chk("closed by sync", 13, c);
    wait_k(12, 13);
    chk("sync end", 12, c);
    txq.push_back({2'b11, 32'hC0DE0004});
    wait_k(14, 14);
    chk("announce", 14, c);
    data_is(32'hC0DE0004);
    wait_k(12, 13);
    chk("sync data end", 12, c);
    apb(1, OFF_CTRL, 32'h9);
    saw_ann = 1'b0;
    txq.push_back({2'b11, 32'hC0DE0005});
    wait_k(12, 12);
    chk("host announce", 0, saw_ann);
    $display("test sync done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1, OFF_CTRL, i < 2 ? 32'h1 : 32'h5);
      rx_free <= (i < 2 ? STOP_THR_LOW : STOP_THR_HIGH) + 16'(i[0]);
      repeat (4) wait_k(15, 16);
      chk("flow word", i[0] ? 16 : 15, c);
      apb(0, OFF_STATUS, 0);
      chk("local stop", !i[0], rd[ST_STOP_BIT]);
    end
    rx_free <= 16'hFFFF;
    $display("test threshold done");
    txq.push_back({2'b00, 32'hC0DE0006});
    for (int f = 0; f < 2; f++)
    begin
      sfl_remote_node_i.put(1, f ? 32'h0E : 32'h12);
      sfl_remote_node_i.put(1, 32'h11);
      sfl_remote_node_i.put(1, 32'h05);
      sfl_remote_node_i.put(0, 32'hA5A50000 + f);
      sfl_remote_node_i.put(1, 32'h0B - f);
      sfl_remote_node_i.put(1, f ? 32'h0C : 32'h0D);
    end
    data_is(32'hC0DE0006);
    repeat (20) @(posedge lclk);
    chk("rx count", 2, rxq.size());
    chk("rx word 0", 32'hA5A50000, rxq[0]);
    chk("rx word 1", 32'hA5A50001, rxq[1]);
    chk("rx syncs", 1, nsync);
    chk("rx side", 6'b100111, {rx_pio1, rx_pio2, rx_dir_n, rx_remote_ovf, rx_nrdy_n, rx_sync_dv});
    $display("test receive done");
    for (int j = 0; j < 513; j++)
      txq.push_back({2'b00, 32'hD0000000 + j});
    for (int j = 0; j < 512; j++)
      data_is(32'hD0000000 + j);
    @(posedge lclk);
    chk("frame limit", 1, lnk_tx_k === 1'b1 && lnk_tx_word[20:16] inside {[5'h08:5'h0B]});
    data_is(32'hD0000200);
    apb(1, OFF_CTRL, 32'h3);
    wait_k(12, 13);
    txq.push_back({2'b00, 32'hC0DE0007});
    data_is(32'hC0DE0007);
    @(posedge lclk);
    chk("tx crc", crc1(32'hC0DE0007), lnk_tx_word);
    for (int f = 0; f < 2; f++)
    begin
      sfl_remote_node_i.put(1, 32'h05);
      sfl_remote_node_i.put(0, 32'hA5A50002 + f);
      sfl_remote_node_i.put(0, crc1(32'hA5A50002 + f) ^ 32'(f));
      sfl_remote_node_i.put(1, 32'h08);
      sfl_remote_node_i.put(1, 32'h0D);
      repeat (12) @(posedge lclk);
      apb(0, OFF_STATUS, 0);
      chk("crc error", f, rd[ST_CRCERR_BIT]);
    end
    chk("rx crc data", 32'hA5A50003, rxq[3]);
    repeat (4100) sfl_remote_node_i.put(1, 32'h05);
    repeat (4110) @(posedge lclk);
    apb(0, OFF_STATUS, 0);
    chk("lost idle", 1, rd[ST_LOST_BIT]);
    apb(1, OFF_STATUS, 32'hC);
    apb(0, OFF_STATUS, 0);
    chk("flags cleared", 0, rd[3:2]);
    $display("test crc and limits done");
    test_done;
  end
endmodule

// [tb/sfl_remote_node.sv]
// remote link node: free link clock, flow padding, injected words
`timescale 1ns/1ps
module sfl_remote_node (
  // link towards the framer
  output logic lclk,
  output logic [31:0] lnk_rx_word,
  output logic lnk_rx_k,
  // flow state to announce
  input wire logic go
);
  import sfl_pkg::*;
  logic [32:0] q[$];
  logic [1:0] ph;
  function automatic logic [31:0] os(input logic [4:0] x);
    return {8'hBC, 3'h0, x, 16'h0000};
  endfunction
  // k words carry only the code in w
  task automatic put(input logic k, input logic [31:0] w);
    q.push_back({k, k ? os(w[4:0]) : w});
  endtask
  initial
  begin
    lclk = 1'b0;
    lnk_rx_k = 1'b1;
    lnk_rx_word = os(OS_IDLE);
    ph = 2'h0;
    #13;
    forever
    begin
      #160;
      lclk = 1'b1;
      #160;
      lclk = 1'b0;
      ph = ph + 2'h1;
      if (q.size() != 0)
        {lnk_rx_k, lnk_rx_word} = q.pop_front();
      else if (ph[0])
        {lnk_rx_k, lnk_rx_word} = {1'b1, os(go ? OS_GO : OS_STOP)};
      else
        {lnk_rx_k, lnk_rx_word} = {1'b1, os(ph[1] ? OS_IDLE : OS_IDLE_POS)};
    end
  end
endmodule

// [verilog/sfl_crc.sv]
// running crc over 32-bit link words
`timescale 1ns/1ps
module sfl_crc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control and data
  input wire logic clr,
  input wire logic upd,
  input wire logic [31:0] d,
  output logic [31:0] crc
);
  import sfl_pkg::*;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = r[31] ^ w[i] ? {r[30:0], 1'b0} ^ CRC_POLY : {r[30:0], 1'b0};
    end
    crc_step = r;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crc <= CRC_INIT;
    else if (ce)
    begin
      if (clr)
        crc <= CRC_INIT;
      else if (upd)
        crc <= crc_step(crc, d);
    end
  end
endmodule

// [verilog/sfl_framer.sv]
// serial link framer: apb registers, frame transmitter, frame receiver
// How it works
// - receiver takes any word stream; idle gap of 4096 words or more flags loss
// - words are 32 bits, ordered sets marked by k flag for 8b/10b coder
// - positive-disparity idle accepted like ordinary idle
// - pio1,pio2,dir value picks one of eight start delimiters
// - sent direction bit is inverse of active-low direction pin
// - overflow,not-ready value picks one of four status delimiters
// - sync frames close with sync end, data frames with data end
// - announce word before a frame marks it sync-with-data
// - receiver sends stop or go as inter-frame padding
// - gaps between frames carry idle words
// - data frame, sync without data, sync with data are supported
// - host variant sends sync only without data
// - sync marker at fifo head closes current frame, then sync frame
// - at most 512 data words per frame, then a new frame
// - five overhead words per frame, six with crc
// - side signals sampled in every frame
// - transmission starts once enabled, with or without data waiting, no login
// - frames flow continuously, data inserted when available
// - data frame words sent only while last flow word from far end was go; a sync-with-data word needs go only at the gap before its frame
// - transmit and receive directions run independently
// - stop sent once free receive space falls to threshold
`timescale 1ns/1ps
module sfl_framer (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit fifo head
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_sync,
  input wire logic tx_sync_dv,
  input wire logic tx_ovf,
  output logic tx_ready,
  // parallel port side pins
  input wire logic pio1,
  input wire logic pio2,
  input wire logic dir_n,
  input wire logic nrdy_n,
  // receive side
  input wire logic [15:0] rx_free,
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic rx_sync,
  output logic rx_sync_dv,
  output logic rx_pio1,
  output logic rx_pio2,
  output logic rx_dir_n,
  output logic rx_nrdy_n,
  output logic rx_remote_ovf,
  // link word port
  input wire logic lclk,
  input wire logic [31:0] lnk_rx_word,
  input wire logic lnk_rx_k,
  output logic [31:0] lnk_tx_word,
  output logic lnk_tx_k
);
  import sfl_pkg::*;

  logic [3:0] ctrl_reg;
  logic crc_err_reg;
  logic lost_reg;
  logic remote_go_reg;
  logic local_stop_reg;
  logic lclk_s;
  logic lclk_d_reg;
  logic slot;
  logic en;
  logic crc_en;
  logic [3:0] side_s;
  logic rx_k_s;
  logic [31:0] rx_word_s;

  assign en = ctrl_reg[CTRL_EN_BIT];
  assign crc_en = ctrl_reg[CTRL_CRC_BIT];

  ////////////////////////////////////////////////////////////////
  // pin synchronisers and link slot detection
  sfl_sync2 #(.W(38)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({lclk, pio1, pio2, dir_n, nrdy_n, lnk_rx_k, lnk_rx_word}),
    .q({lclk_s, side_s, rx_k_s, rx_word_s})
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lclk_d_reg <= 1'b0;
    else if (ce)
      lclk_d_reg <= lclk_s;
  end

  // one word slot per link clock rise, both directions
  assign slot = lclk_s && !lclk_d_reg;

  ////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  logic access;
  logic wr;
  logic mapped;
  logic crc_err_set;
  logic lost_set;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS);
  assign pslverr = access && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RESET;
    else if (ce && wr && paddr == OFF_CTRL)
      ctrl_reg <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && psel && !penable)
    begin
      if (paddr == OFF_CTRL)
        prdata <= {28'h000_0000, ctrl_reg};
      else if (paddr == OFF_STATUS)
        prdata <= {28'h000_0000, lost_reg, crc_err_reg, local_stop_reg, remote_go_reg};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_err_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (crc_err_set)
        crc_err_reg <= 1'b1;
      else if (wr && paddr == OFF_STATUS && pwdata[ST_CRCERR_BIT])
        crc_err_reg <= 1'b0;
      if (lost_set)
        lost_reg <= 1'b1;
      else if (wr && paddr == OFF_STATUS && pwdata[ST_LOST_BIT])
        lost_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      local_stop_reg <= 1'b0;
    else if (ce)
      local_stop_reg <= rx_free <= (ctrl_reg[CTRL_RATE_BIT] ? STOP_THR_HIGH : STOP_THR_LOW);
  end

  ////////////////////////////////////////////////////////////////
  // transmitter
  sfl_tx_state_t tx_state_reg;
  logic [9:0] tx_cnt_reg;
  logic frm_sync_reg;
  logic frm_dv_reg;
  logic dv_done_reg;
  logic [31:0] tx_crc;
  logic head_sync;
  logic head_data;
  logic send_data;
  logic pop_marker;
  logic tx_step;

  assign tx_step = slot && en;
  assign head_sync = tx_valid && tx_sync && remote_go_reg;
  assign head_data = tx_valid && !tx_sync && remote_go_reg;
  // sync with data sends the marker's word; data frames take fifo words
  assign send_data = tx_state_reg == TX_DATA &&
    (frm_sync_reg ? frm_dv_reg && !dv_done_reg : head_data && tx_cnt_reg < MAX_DATA_WORDS);
  assign pop_marker = tx_state_reg == TX_SOF && frm_sync_reg && !frm_dv_reg;
  assign tx_ready = tx_step && (send_data || pop_marker);

  sfl_crc u_tx_crc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clr(tx_step && tx_state_reg == TX_SOF),
    .upd(tx_step && send_data),
    .d(tx_data),
    .crc(tx_crc)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= TX_GAP_FLOW;
      tx_cnt_reg <= 10'h000;
      frm_sync_reg <= 1'b0;
      frm_dv_reg <= 1'b0;
      dv_done_reg <= 1'b0;
      lnk_tx_word <= 32'h0000_0000;
      lnk_tx_k <= 1'b0;
    end
    else if (ce && slot)
    begin
      lnk_tx_k <= 1'b1;
      if (!en)
      begin
        lnk_tx_word <= sfl_os_word(OS_IDLE);
        tx_state_reg <= TX_GAP_FLOW;
      end
      else
      begin
        case (tx_state_reg)
          TX_GAP_FLOW:
          begin
            frm_sync_reg <= head_sync;
            frm_dv_reg <= head_sync && tx_sync_dv && !ctrl_reg[CTRL_HOSTVAR_BIT];
            dv_done_reg <= 1'b0;
            if (head_sync && tx_sync_dv && !ctrl_reg[CTRL_HOSTVAR_BIT])
              lnk_tx_word <= sfl_os_word(OS_ANNC);
            else
              lnk_tx_word <= sfl_os_word(local_stop_reg ? OS_STOP : OS_GO);
            tx_state_reg <= TX_GAP_IDLE;
          end
          TX_GAP_IDLE:
          begin
            lnk_tx_word <= sfl_os_word(OS_IDLE);
            tx_state_reg <= TX_SOF;
          end
          TX_SOF:
          begin
            // sent direction is active high
            lnk_tx_word <= sfl_os_word(sfl_sof_code({side_s[3], side_s[2], !side_s[1]}));
            tx_cnt_reg <= 10'h000;
            tx_state_reg <= TX_DATA;
          end
          TX_DATA:
          begin
            if (send_data)
            begin
              lnk_tx_word <= tx_data;
              lnk_tx_k <= 1'b0;
              tx_cnt_reg <= tx_cnt_reg + 10'h001;
              dv_done_reg <= 1'b1;
            end
            else if (crc_en)
            begin
              lnk_tx_word <= tx_crc;
              lnk_tx_k <= 1'b0;
              tx_state_reg <= TX_STS;
            end
            else
            begin
              lnk_tx_word <= sfl_os_word(sfl_sts_code({tx_ovf, !side_s[0]}));
              tx_state_reg <= TX_EOF;
            end
          end
          TX_STS:
          begin
            lnk_tx_word <= sfl_os_word(sfl_sts_code({tx_ovf, !side_s[0]}));
            tx_state_reg <= TX_EOF;
          end
          TX_EOF:
          begin
            lnk_tx_word <= sfl_os_word(frm_sync_reg ? OS_EOF_SYNC : OS_EOF_DATA);
            tx_state_reg <= TX_GAP_FLOW;
          end
          default:
            tx_state_reg <= TX_GAP_FLOW;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receiver
  logic rx_step;
  logic is_os;
  logic [4:0] rx_code;
  logic [31:0] held_reg;
  logic held_v_reg;
  logic annc_reg;
  logic [2:0] sof_bits_reg;
  logic [1:0] sts_bits_reg;
  logic [12:0] idle_cnt_reg;
  logic emit;
  logic [31:0] rx_crc;

  assign rx_step = slot && en;
  assign is_os = rx_k_s && rx_word_s[31:24] == OS_MARK;
  assign rx_code = rx_word_s[20:16];
  // one word held back, since the crc is only known at the status end
  assign emit = rx_step && held_v_reg &&
    (!is_os || (rx_code[4:2] == 3'b010 && !crc_en));
  assign crc_err_set = rx_step && held_v_reg && is_os && rx_code[4:2] == 3'b010 &&
    crc_en && held_reg != rx_crc;
  assign lost_set = rx_step && idle_cnt_reg == IDLE_SPAN_WORDS;

  sfl_crc u_rx_crc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clr(rx_step && is_os && rx_code[4:3] == 2'b00),
    .upd(emit),
    .d(held_reg),
    .crc(rx_crc)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_valid <= 1'b0;
      rx_data <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rx_valid <= emit;
      if (emit)
        rx_data <= held_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_cnt_reg <= 13'h0000;
    else if (ce && rx_step)
    begin
      if (is_os && (rx_code == OS_IDLE || rx_code == OS_IDLE_POS))
        idle_cnt_reg <= 13'h0000;
      else if (idle_cnt_reg != IDLE_SPAN_WORDS)
        idle_cnt_reg <= idle_cnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_reg <= 32'h0000_0000;
      held_v_reg <= 1'b0;
      annc_reg <= 1'b0;
      sof_bits_reg <= 3'h0;
      sts_bits_reg <= 2'h0;
      remote_go_reg <= 1'b0;
      rx_sync <= 1'b0;
      rx_sync_dv <= 1'b0;
      rx_pio1 <= 1'b0;
      rx_pio2 <= 1'b0;
      rx_dir_n <= 1'b1;
      rx_nrdy_n <= 1'b1;
      rx_remote_ovf <= 1'b0;
    end
    else if (ce)
    begin
      rx_sync <= 1'b0;
      if (rx_step && !is_os)
      begin
        held_reg <= rx_word_s;
        held_v_reg <= 1'b1;
      end
      else if (rx_step)
      begin
        if (rx_code[4:3] == 2'b00)
        begin
          sof_bits_reg <= rx_code[2:0];
          held_v_reg <= 1'b0;
        end
        else if (rx_code[4:2] == 3'b010)
        begin
          sts_bits_reg <= rx_code[1:0];
          held_v_reg <= 1'b0;
        end
        else if (rx_code == OS_EOF_DATA || rx_code == OS_EOF_SYNC)
        begin
          rx_pio1 <= sof_bits_reg[2];
          rx_pio2 <= sof_bits_reg[1];
          rx_dir_n <= !sof_bits_reg[0];
          rx_remote_ovf <= sts_bits_reg[1];
          rx_nrdy_n <= !sts_bits_reg[0];
          rx_sync <= rx_code == OS_EOF_SYNC;
          rx_sync_dv <= rx_code == OS_EOF_SYNC && annc_reg;
          annc_reg <= 1'b0;
        end
        else if (rx_code == OS_ANNC)
          annc_reg <= 1'b1;
        else if (rx_code == OS_STOP)
          remote_go_reg <= 1'b0;
        else if (rx_code == OS_GO)
          remote_go_reg <= 1'b1;
      end
    end
  end
endmodule

// [verilog/sfl_sync2.sv]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sfl_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
